// ===== bench/mclp_src_model.sv
// Far-side model: source clocks as one-cycle enable pulses on clk_sys.
// Assumes the bench may stop the crystal to provoke a clock loss.
`timescale 1ns/1ps
module mclp_src_model
  import mclp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic crystalOff,
  output mclp_src_type srcTick
);
  // Wraps at 60 so every source period stays regular
  logic [7:0] cnt_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      srcTick <= '0;
    end else begin
      cnt_r <= (cnt_r == 8'h3b) ? 8'h00 : cnt_r + 8'h01;
      srcTick.crystal <= !crystalOff && cnt_r[0];
      srcTick.mainPll <= 1'b1;
      srcTick.fastOsc <= (cnt_r % 3) == 0;
      srcTick.slowOsc <= (cnt_r % 5) == 0;
      srcTick.extClk <= cnt_r[1:0] == 2'h0;
      srcTick.usbPll <= 1'b1;
      srcTick.usbRef <= (cnt_r % 3) == 1;
    end
  end
endmodule : mclp_src_model

// ===== bench/mclp_top_tb_top.sv
// Self-checking bench for the master clock and low-power controller.
// Assumes zero-wait APB and one-cycle source enable pulses.
`timescale 1ns/1ps
module mclp_top_tb_top
  import mclp_pkg::*;
();
  logic clk_sys = 1'b0, rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic accessFromCtl = 1'b0, crystalOff = 1'b0, pready, pslverr, er;
  mclp_src_type srcTick;
  mclp_core_type core = '0;
  logic systemPllTick, masterTick, cpuTick, analogTick, usbTick, canTick;
  logic watchdogTick, mainPllOn, usbPllOn, ctlCpuClkOn, sharedClkOn;
  logic clockFail;
  logic [MCLP_NPER-1:0] periphTick;
  mclp_mode_type mode;
  logic [6:0] mainPllMult;
  logic [5:0] usbPllMult;
  logic [8:0] obsAll;
  logic [6:0] refAll;
  int failCount = 0, checks = 0, n;

  mclp_top DUT (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .accessFromCtl, .prdata, .pready, .pslverr, .srcTick, .core,
    .systemPllTick, .masterTick, .cpuTick, .analogTick, .periphTick,
    .usbTick, .canTick, .watchdogTick, .mainPllOn, .usbPllOn,
    .ctlCpuClkOn, .sharedClkOn, .clockFail, .mode, .mainPllMult,
    .usbPllMult);
  mclp_src_model uSrc (.clk_sys, .rst, .crystalOff, .srcTick);

  assign obsAll = {watchdogTick, canTick, usbTick, cpuTick, periphTick[1],
    periphTick[0], analogTick, masterTick, systemPllTick};
  assign refAll = {srcTick.mainPll, srcTick.extClk, srcTick.usbRef,
    srcTick.slowOsc, srcTick.fastOsc, srcTick.usbPll, srcTick.crystal};

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic ctl);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    accessFromCtl <= ctl;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) failCount++;
    @(negedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  // Source ticks between two output ticks, taken on the third period after the first tick seen
  task automatic gap(input int s, input int r, input int e);
    int c;
    int k;
    c = 0;
    k = 0;
    repeat (2) begin
      c = 0;
      do @(negedge clk_sys); while (obsAll[s] !== 1'b1 && ++k < 500);
      do begin
        @(negedge clk_sys);
        k++;
        if (refAll[r] === 1'b1) c++;
      end while (obsAll[s] !== 1'b1 && k < 500);
    end
    check(32'(c), 32'(e));
  endtask : gap

  task automatic cnt(input int s, output int c);
    c = 0;
    repeat (30) begin
      @(negedge clk_sys);
      if (obsAll[s] === 1'b1) c++;
    end
  endtask : cnt

  // Pulse bits drop after one cycle, level bits stay
  task automatic ev(input logic [4:0] v);
    @(posedge clk_sys);
    core <= v;
    @(posedge clk_sys);
    core <= v & 5'h0c;
    @(negedge clk_sys);
  endtask : ev

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check(mode, MCLP_RUN);
    check({mainPllOn, usbPllOn, ctlCpuClkOn, sharedClkOn}, 4'hf);
    check(clockFail, 1'b0);
    check(usbPllMult, MCLP_USBMULT_BYPASS);
  endtask : t_reset

  task automatic t_usb();
    wr(MCLP_USBMULT_OFS, 32'h0000003f);
    check(usbPllMult, 6'h3f);
    gap(6, 1, 4);
    wr(MCLP_USBMULT_OFS, 32'h0);
    gap(6, 4, 1);
    apb(1'b0, 8'h80, 32'h0, 1'b0);
    check(er, 1'b1);
    check(rd, 32'h0);
  endtask : t_usb

  task automatic t_owner();
    apb(1'b1, MCLP_SYSDIV_OFS, 32'h3, 1'b1);
    check(er, 1'b1);
    apb(1'b1, MCLP_CTLREQ_OFS, 32'h1, 1'b1);
    apb(1'b1, MCLP_SYSDIV_OFS, 32'h3, 1'b1);
    check(er, 1'b0);
    apb(1'b1, MCLP_SYSDIV_OFS, 32'h2, 1'b0);
    check(er, 1'b1);
    apb(1'b1, MCLP_MRECL_OFS, 32'h1, 1'b0);
    apb(1'b0, MCLP_SYSDIV_OFS, 32'h0, 1'b0);
    check(rd[2:0], 3'h3);
    apb(1'b0, MCLP_STAT_OFS, 32'h0, 1'b0);
    check(rd[1], 1'b0);
  endtask : t_owner

  task automatic t_div();
    gap(0, 0, 3);
    wr(MCLP_MDIV_OFS, 32'h2);
    gap(1, 0, 6);
    wr(MCLP_ACLK_OFS, 32'h2);
    gap(2, 0, 6);
    gap(8, 0, 1);
    wr(MCLP_CANSEL_OFS, 32'h2);
    gap(7, 5, 1);
    wr(MCLP_CANSEL_OFS, 32'h1);
    gap(7, 0, 1);
    wr(MCLP_PLLMULT_OFS, 32'h0000007f);
    check(mainPllMult, 7'h7f);
    wr(MCLP_PLLCTL_OFS, 32'h1);
    gap(0, 6, 3);
    wr(MCLP_PLLCTL_OFS, 32'h0);
  endtask : t_div

  task automatic t_lp();
    wr(MCLP_DCEN_OFS, 32'h0000fffe);
    cnt(3, n);
    check(32'(n), 32'h0);
    gap(4, 0, 6);
    wr(MCLP_SLPGATE_OFS, 32'h0);
    wr(MCLP_RUNCFG_OFS, 32'h1);
    ev(5'h10);
    check(mode, MCLP_SLEEP);
    cnt(4, n);
    check(32'(n), 32'h0);
    cnt(5, n);
    check(32'(n), 32'h0);
    ev(5'h02);
    check(mode, MCLP_RUN);
    wr(MCLP_RUNCFG_OFS, 32'h0);
    ev(5'h10);
    gap(4, 0, 6);
    ev(5'h06);
    check(mode, MCLP_RUN);
    ev(5'h05);
    check(mode, MCLP_SLEEP);
    ev(5'h02);
    ev(5'h01);
    check(mode, MCLP_RUN);
    wr(MCLP_DSLP_OFS, 32'h32);
    ev(5'h18);
    check(mode, MCLP_DEEP);
    check({mainPllOn, usbPllOn, ctlCpuClkOn, sharedClkOn}, 4'h0);
    gap(1, 3, 4);
    cnt(2, n);
    check(32'(n), 32'h0);
    ev(5'h02);
    check(mode, MCLP_RUN);
  endtask : t_lp

  task automatic t_fail();
    @(posedge clk_sys);
    crystalOff <= 1'b1;
    for (int i = 0; i < 100 && clockFail !== 1'b1; i++) @(negedge clk_sys);
    check(clockFail, 1'b1);
    gap(0, 2, 1);
    gap(2, 2, 1);
    gap(1, 2, 2);
    apb(1'b0, MCLP_STAT_OFS, 32'h0, 1'b0);
    check(rd[0], 1'b1);
    wr(MCLP_STAT_OFS, 32'h1);
    check(clockFail, 1'b0);
  endtask : t_fail

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic end_sim();
    if (failCount == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_usb();
    t_owner();
    t_div();
    t_lp();
    t_fail();
    end_sim();
  end
endmodule : mclp_top_tb_top

// ===== common/mclp_pkg.sv
// Constants and types for the master clock and low-power controller.
// Assumes a 50 MHz system clock and an APB register port.
package mclp_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] MCLP_PLLCTL_OFS = 8'h00;
  localparam logic [7:0] MCLP_PLLMULT_OFS = 8'h04;
  localparam logic [7:0] MCLP_PLLSTAT_OFS = 8'h08;
  localparam logic [7:0] MCLP_SYSDIV_OFS = 8'h0c;
  localparam logic [7:0] MCLP_MDIV_OFS = 8'h10;
  localparam logic [7:0] MCLP_ACLK_OFS = 8'h14;
  localparam logic [7:0] MCLP_DSLP_OFS = 8'h18;
  localparam logic [7:0] MCLP_RUNCFG_OFS = 8'h1c;
  localparam logic [7:0] MCLP_RUNGATE_OFS = 8'h20;
  localparam logic [7:0] MCLP_SLPGATE_OFS = 8'h24;
  localparam logic [7:0] MCLP_DPGATE_OFS = 8'h28;
  localparam logic [7:0] MCLP_DCEN_OFS = 8'h2c;
  localparam logic [7:0] MCLP_CTLREQ_OFS = 8'h30;
  localparam logic [7:0] MCLP_MRECL_OFS = 8'h34;
  localparam logic [7:0] MCLP_USBMULT_OFS = 8'h38;
  localparam logic [7:0] MCLP_STAT_OFS = 8'h3c;
  localparam logic [7:0] MCLP_CANSEL_OFS = 8'h40;

  // ----------------------------------------------------------------
  // Fields, sizes and reset values
  // ----------------------------------------------------------------
  localparam int MCLP_NPER = 16;
  localparam int MCLP_STAT_FAIL_BIT = 0;
  localparam int MCLP_STAT_OWNER_BIT = 1;
  localparam int MCLP_STAT_MODE_LSB = 2;
  localparam logic [2:0] MCLP_DIV_RST = 3'h1;
  localparam logic [7:0] MCLP_USB_DIV = 8'h04;
  localparam logic [7:0] MCLP_MISS_LIMIT = 8'h08;
  localparam logic [6:0] MCLP_PLLMULT_RST = 7'h00;
  localparam logic [5:0] MCLP_USBMULT_BYPASS = 6'h00;
  localparam logic [MCLP_NPER-1:0] MCLP_GATE_RST = 16'hffff;

  // Clock source codes
  localparam logic [1:0] MCLP_SRC_OSC = 2'h0;
  localparam logic [1:0] MCLP_SRC_PLL = 2'h1;
  localparam logic [1:0] MCLP_SRC_FAST = 2'h2;
  localparam logic [1:0] MCLP_SRC_SLOW = 2'h3;

  // CAN source codes
  localparam logic [1:0] MCLP_CAN_MASTER = 2'h0;
  localparam logic [1:0] MCLP_CAN_OSC = 2'h1;
  localparam logic [1:0] MCLP_CAN_EXT = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCLP_RUN,
    MCLP_SLEEP,
    MCLP_DEEP
  } mclp_mode_type;

  typedef struct packed {
    logic pulse;
    logic [7:0] cnt;
  } mclp_div_type;

  typedef struct packed {
    logic waitIrq;
    logic deepSleepSel;
    logic sleepOnExit;
    logic wakeIrq;
    logic isrReturn;
  } mclp_core_type;

  typedef struct packed {
    logic crystal;
    logic mainPll;
    logic fastOsc;
    logic slowOsc;
    logic extClk;
    logic usbPll;
    logic usbRef;
  } mclp_src_type;

endpackage : mclp_pkg

// ===== logic/mclp_top.sv
// Master clock generation, clock-loss fallback and low-power control.
// Assumes all source clocks arrive as one-cycle enable pulses that are
// synchronous to clk_sys, and one APB master shared by both processors.
//
// Summary of operation
// - System PLL clock is divided main PLL or crystal clock, per PLL enable.
// - Missing-clock detector on crystal; on loss fast osc replaces PLL clock.
// - Clock loss raises clock-fail towards NMI and control subsystem.
// - Slow and fast internal oscillators can feed the deep-sleep clock.
// - PLL registers writable by master; control CPU requests, master reclaims.
// - Master subsystem is in exactly one of Run, Sleep, Deep Sleep.
// - Deep Sleep stops both PLLs, control, shared and analog clocks.
// - Master clock is system clock divided by master divider; on loss, fast osc divided by it.
// - System PLL clock is PLL or oscillator divided by system divider.
// - Analog clock is system clock divided; fast oscillator on loss.
// - Deep-sleep clock is selected, divided, then divided by master divider.
// - In Sleep, auto-gating 0 uses run gating, 1 uses sleep gating.
// - Gating settings apply only to peripherals enabled in device config.
// - Wait-for-interrupt stops the core, enters Sleep or Deep by select bit.
// - A configured interrupt ends Sleep or Deep Sleep, back to Run.
// - Sleep-on-exit 1 sleeps again after the waking routine; 0 stays awake.
// - Sleep clocks enabled peripherals at their Run frequency.
// - Run clocks core from master clock, USB from its PLL, CAN and watchdog.
// - USB PLL integer multiplier codes map directly, up to 63.
// - USB multiplier code zero bypasses the PLL reference to USB clock.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module mclp_top
  import mclp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic accessFromCtl,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mclp_src_type srcTick,
  input wire mclp_core_type core,
  output logic systemPllTick,
  output logic masterTick,
  output logic cpuTick,
  output logic analogTick,
  output logic [MCLP_NPER-1:0] periphTick,
  output logic usbTick,
  output logic canTick,
  output logic watchdogTick,
  output logic mainPllOn,
  output logic usbPllOn,
  output logic ctlCpuClkOn,
  output logic sharedClkOn,
  output logic clockFail,
  output mclp_mode_type mode,
  output logic [6:0] mainPllMult,
  output logic [5:0] usbPllMult
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mclp_mode_type mode;
    logic isrOnly;
    logic backDeep;
    logic pllEn;
    logic [6:0] pllMult;
    logic [2:0] sysDiv;
    logic [2:0] mDiv;
    logic [2:0] aDiv;
    logic [1:0] dsSrc;
    logic [3:0] dsDiv;
    logic autoGate;
    logic [MCLP_NPER-1:0] runGate;
    logic [MCLP_NPER-1:0] sleepGate;
    logic [MCLP_NPER-1:0] deepGate;
    logic [MCLP_NPER-1:0] perEn;
    logic [5:0] usbMult;
    logic [1:0] canSel;
    logic ctlOwner;
    logic fail;
    logic [7:0] missCnt;
    logic [1:0] sysSel;
    logic aFast;
    logic mDeep;
    logic [1:0] dsSel;
    logic [7:0] sysCnt;
    logic [7:0] mCnt;
    logic [7:0] aCnt;
    logic [7:0] dsCnt;
    logic [7:0] uCnt;
    logic [31:0] rdata;
    logic err;
  } mclp_state_type;

  mclp_state_type st_r;
  mclp_state_type st_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] divOf(input logic [3:0] code);
    divOf = (code == 4'h0) ? 8'h01 : {4'h0, code};
  endfunction : divOf

  function automatic mclp_div_type divStep(input logic [7:0] cnt,
                                           input logic tick,
                                           input logic [7:0] div);
    mclp_div_type r;
    r.pulse = 1'b0;
    r.cnt = cnt;
    if (tick) begin
      if (cnt + 8'h01 >= div) begin
        r.pulse = 1'b1;
        r.cnt = 8'h00;
      end else begin
        r.cnt = cnt + 8'h01;
      end
    end
    divStep = r;
  endfunction : divStep

  function automatic logic pickSrc(input logic [1:0] sel,
                                   input mclp_src_type s);
    unique case (sel)
      MCLP_SRC_OSC: pickSrc = s.crystal;
      MCLP_SRC_PLL: pickSrc = s.mainPll;
      MCLP_SRC_FAST: pickSrc = s.fastOsc;
      MCLP_SRC_SLOW: pickSrc = s.slowOsc;
    endcase
  endfunction : pickSrc

  // ----------------------------------------------------------------
  // Clock tree
  // ----------------------------------------------------------------
  logic isDeep;
  logic [1:0] sysWant;
  mclp_div_type sysD;
  mclp_div_type mD;
  mclp_div_type aD;
  mclp_div_type dsD;
  mclp_div_type uD;
  logic [MCLP_NPER-1:0] gateSel;

  assign isDeep = (st_r.mode == MCLP_DEEP);
  assign sysWant = st_r.fail ? MCLP_SRC_FAST :
                   (st_r.pllEn ? MCLP_SRC_PLL : MCLP_SRC_OSC);

  // System divider; a lost source is replaced by the raw fast oscillator
  assign sysD = divStep(st_r.sysCnt, pickSrc(st_r.sysSel, srcTick),
                        divOf({1'b0, st_r.sysDiv}));
  assign systemPllTick = !isDeep &&
    ((st_r.sysSel == MCLP_SRC_FAST) ? srcTick.fastOsc : sysD.pulse);

  // Deep-sleep source and its own divider
  assign dsD = divStep(st_r.dsCnt, pickSrc(st_r.dsSel, srcTick),
                       divOf(st_r.dsDiv));

  // Master divider: system clock normally, deep-sleep clock in Deep
  assign mD = divStep(st_r.mCnt, st_r.mDeep ? dsD.pulse : systemPllTick,
                      divOf({1'b0, st_r.mDiv}));
  assign masterTick = mD.pulse;
  assign cpuTick = mD.pulse && (st_r.mode == MCLP_RUN);

  // Analog divider
  assign aD = divStep(st_r.aCnt, systemPllTick,
                      divOf({1'b0, st_r.aDiv}));
  assign analogTick = !isDeep &&
    (st_r.aFast ? srcTick.fastOsc : aD.pulse);

  // USB: divide by four, or pass reference when bypassed
  assign uD = divStep(st_r.uCnt, srcTick.usbPll, MCLP_USB_DIV);
  assign usbTick = !isDeep &&
    ((st_r.usbMult == MCLP_USBMULT_BYPASS) ?
     srcTick.usbRef : uD.pulse);

  // Peripheral gating
  always_comb begin
    gateSel = st_r.runGate;
    if (st_r.autoGate && st_r.mode == MCLP_SLEEP) begin
      gateSel = st_r.sleepGate;
    end else if (st_r.autoGate && isDeep) begin
      gateSel = st_r.deepGate;
    end
  end
  // Same master tick in Run and Sleep keeps Run frequency
  assign periphTick = {MCLP_NPER{mD.pulse}} & gateSel
                      & st_r.perEn;

  always_comb begin
    unique case (st_r.canSel)
      MCLP_CAN_OSC: canTick = srcTick.crystal;
      MCLP_CAN_EXT: canTick = srcTick.extClk;
      default: canTick = mD.pulse;
    endcase
  end
  assign watchdogTick = srcTick.crystal;

  assign mainPllOn = !isDeep;
  assign usbPllOn = !isDeep;
  assign ctlCpuClkOn = !isDeep;
  assign sharedClkOn = !isDeep;
  assign clockFail = st_r.fail;
  assign mode = st_r.mode;
  assign mainPllMult = st_r.pllMult;
  assign usbPllMult = st_r.usbMult;

  // ----------------------------------------------------------------
  // APB port
  // ----------------------------------------------------------------
  logic setup;
  logic wrAcc;
  logic pllReg;
  logic wrOk;
  logic [31:0] rdVal;
  logic mapped;

  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  assign pllReg = (paddr == MCLP_PLLCTL_OFS) ||
                  (paddr == MCLP_PLLMULT_OFS) ||
                  (paddr == MCLP_PLLSTAT_OFS) ||
                  (paddr == MCLP_SYSDIV_OFS);
  assign wrOk = !pllReg || (accessFromCtl == st_r.ctlOwner);
  assign pready = 1'b1;
  assign prdata = st_r.rdata;
  assign pslverr = psel && penable && st_r.err;

  always_comb begin
    rdVal = 32'h0;
    mapped = 1'b1;
    unique case (paddr)
      MCLP_PLLCTL_OFS: rdVal = {31'h0, st_r.pllEn};
      MCLP_PLLMULT_OFS: rdVal = {25'h0, st_r.pllMult};
      MCLP_PLLSTAT_OFS: rdVal = {30'h0, st_r.ctlOwner, st_r.fail};
      MCLP_SYSDIV_OFS: rdVal = {29'h0, st_r.sysDiv};
      MCLP_MDIV_OFS: rdVal = {29'h0, st_r.mDiv};
      MCLP_ACLK_OFS: rdVal = {29'h0, st_r.aDiv};
      MCLP_DSLP_OFS: rdVal = {26'h0, st_r.dsSrc, st_r.dsDiv};
      MCLP_RUNCFG_OFS: rdVal = {31'h0, st_r.autoGate};
      MCLP_RUNGATE_OFS: rdVal = {16'h0, st_r.runGate};
      MCLP_SLPGATE_OFS: rdVal = {16'h0, st_r.sleepGate};
      MCLP_DPGATE_OFS: rdVal = {16'h0, st_r.deepGate};
      MCLP_DCEN_OFS: rdVal = {16'h0, st_r.perEn};
      MCLP_CTLREQ_OFS: rdVal = {31'h0, st_r.ctlOwner};
      MCLP_MRECL_OFS: rdVal = {31'h0, !st_r.ctlOwner};
      MCLP_USBMULT_OFS: rdVal = {26'h0, st_r.usbMult};
      MCLP_STAT_OFS: rdVal = {28'h0, st_r.mode, st_r.ctlOwner, st_r.fail};
      MCLP_CANSEL_OFS: rdVal = {30'h0, st_r.canSel};
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Read data and error are fixed in the setup phase
    if (setup) begin
      st_nxt.rdata = pwrite ? 32'h0 : rdVal;
      st_nxt.err = !mapped || (pwrite && !wrOk);
    end
    if (wrAcc && wrOk) begin
      unique case (paddr)
        MCLP_PLLCTL_OFS: st_nxt.pllEn = pwdata[0];
        MCLP_PLLMULT_OFS: st_nxt.pllMult = pwdata[6:0];
        MCLP_SYSDIV_OFS: st_nxt.sysDiv = pwdata[2:0];
        MCLP_MDIV_OFS: st_nxt.mDiv = pwdata[2:0];
        MCLP_ACLK_OFS: st_nxt.aDiv = pwdata[2:0];
        MCLP_DSLP_OFS: begin
          st_nxt.dsDiv = pwdata[3:0];
          st_nxt.dsSrc = pwdata[5:4];
        end
        MCLP_RUNCFG_OFS: st_nxt.autoGate = pwdata[0];
        MCLP_RUNGATE_OFS: st_nxt.runGate = pwdata[MCLP_NPER-1:0];
        MCLP_SLPGATE_OFS: st_nxt.sleepGate = pwdata[MCLP_NPER-1:0];
        MCLP_DPGATE_OFS: st_nxt.deepGate = pwdata[MCLP_NPER-1:0];
        MCLP_DCEN_OFS: st_nxt.perEn = pwdata[MCLP_NPER-1:0];
        MCLP_CTLREQ_OFS: begin
          if (accessFromCtl && pwdata[0]) begin
            st_nxt.ctlOwner = 1'b1;
          end
        end
        MCLP_MRECL_OFS: begin
          if (!accessFromCtl && pwdata[0]) begin
            st_nxt.ctlOwner = 1'b0;
          end
        end
        MCLP_USBMULT_OFS: st_nxt.usbMult = pwdata[5:0];
        MCLP_STAT_OFS: begin
          if (pwdata[MCLP_STAT_FAIL_BIT]) begin
            st_nxt.fail = 1'b0;
          end
        end
        MCLP_CANSEL_OFS: st_nxt.canSel = pwdata[1:0];
        default: st_nxt.err = st_r.err;
      endcase
    end

    // Missing-clock detector counts fast ticks between crystal ticks
    if (srcTick.crystal) begin
      st_nxt.missCnt = 8'h00;
    end else if (srcTick.fastOsc && st_r.missCnt != MCLP_MISS_LIMIT) begin
      st_nxt.missCnt = st_r.missCnt + 8'h01;
    end
    if (!srcTick.crystal && srcTick.fastOsc &&
        st_r.missCnt == MCLP_MISS_LIMIT - 8'h01) begin
      st_nxt.fail = 1'b1;
    end

    // Dividers advance; sources change at a count of zero, the system source also at once on loss, the master source at once on entering Deep
    st_nxt.sysCnt = sysD.cnt;
    st_nxt.mCnt = mD.cnt;
    st_nxt.aCnt = aD.cnt;
    st_nxt.dsCnt = dsD.cnt;
    st_nxt.uCnt = uD.cnt;
    // A lost source gives no more pulses, so switching at once cuts none
    if (sysD.cnt == 8'h00 || st_r.fail) begin
      st_nxt.sysSel = sysWant;
    end
    if (aD.cnt == 8'h00) begin
      st_nxt.aFast = st_r.fail;
    end
    if (mD.cnt == 8'h00) begin
      st_nxt.mDeep = isDeep;
    end else if (isDeep && !st_r.mDeep) begin
      // System clock already stopped: a stuck count would never reach zero
      st_nxt.mDeep = 1'b1;
      st_nxt.mCnt = 8'h00;
    end
    if (dsD.cnt == 8'h00) begin
      st_nxt.dsSel = (st_r.dsSrc == MCLP_SRC_PLL) ?
                     MCLP_SRC_OSC : st_r.dsSrc;
    end

    // Power modes
    unique case (st_r.mode)
      MCLP_RUN: begin
        if (st_r.isrOnly && core.isrReturn) begin
          st_nxt.isrOnly = 1'b0;
          st_nxt.mode = st_r.backDeep ? MCLP_DEEP : MCLP_SLEEP;
        end else if (core.waitIrq) begin
          st_nxt.backDeep = core.deepSleepSel;
          st_nxt.mode = core.deepSleepSel ? MCLP_DEEP : MCLP_SLEEP;
        end
      end
      MCLP_SLEEP, MCLP_DEEP: begin
        if (core.wakeIrq) begin
          st_nxt.mode = MCLP_RUN;
          st_nxt.isrOnly = core.sleepOnExit;
        end
      end
      default: st_nxt.mode = MCLP_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.mode <= MCLP_RUN;
      st_r.sysDiv <= MCLP_DIV_RST;
      st_r.mDiv <= MCLP_DIV_RST;
      st_r.aDiv <= MCLP_DIV_RST;
      st_r.pllMult <= MCLP_PLLMULT_RST;
      st_r.usbMult <= MCLP_USBMULT_BYPASS;
      st_r.runGate <= MCLP_GATE_RST;
      st_r.sleepGate <= MCLP_GATE_RST;
      st_r.deepGate <= MCLP_GATE_RST;
      st_r.perEn <= MCLP_GATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_DEEP_OFF: assert property (
    isDeep |-> !mainPllOn && !usbPllOn && !ctlCpuClkOn && !analogTick)
    else $error("clocks running in deep sleep");
  AST_WAIT_SLEEP: assert property (
    st_r.mode == MCLP_RUN && !st_r.isrOnly && core.waitIrq &&
    !core.deepSleepSel |=> st_r.mode == MCLP_SLEEP && !cpuTick)
    else $error("wait did not enter sleep");
  AST_WAIT_DEEP: assert property (
    st_r.mode == MCLP_RUN && !st_r.isrOnly && core.waitIrq &&
    core.deepSleepSel |=> isDeep ##1 (isDeep || $past(core.wakeIrq)))
    else $error("wait did not enter deep sleep");
  AST_WAKE: assert property (
    st_r.mode != MCLP_RUN && core.wakeIrq |=> st_r.mode == MCLP_RUN)
    else $error("interrupt did not wake");
  AST_SLEEP_EXIT: assert property (
    st_r.mode == MCLP_RUN && st_r.isrOnly && core.isrReturn
    |=> st_r.mode != MCLP_RUN)
    else $error("no return to low power after routine");
  AST_FAIL_SET: assert property (
    !srcTick.crystal && srcTick.fastOsc &&
    st_r.missCnt == MCLP_MISS_LIMIT - 8'h01 |=> clockFail [*2])
    else $error("clock loss not flagged");
  AST_FAIL_SUB: assert property (
    st_r.fail |=> isDeep || systemPllTick == srcTick.fastOsc)
    else $error("fast oscillator not substituted");
  AST_OWNER: assert property (
    wrAcc && pllReg && accessFromCtl != st_r.ctlOwner
    |=> $stable(st_r.pllEn) && $stable(st_r.pllMult) &&
    $stable(st_r.sysDiv))
    else $error("pll register written without ownership");
  AST_GATE_EN: assert property (
    (periphTick & ~st_r.perEn) == '0)
    else $error("disabled peripheral clocked");
  AST_SLEEP_GATE: assert property (
    st_r.mode == MCLP_SLEEP && !st_r.autoGate |->
    periphTick == ({MCLP_NPER{masterTick}} & st_r.runGate & st_r.perEn))
    else $error("sleep gating wrong with auto gating off");
  AST_USB_BYP: assert property (
    !isDeep && st_r.usbMult == MCLP_USBMULT_BYPASS |->
    usbTick == srcTick.usbRef)
    else $error("usb bypass not applied");

  COV_SLEEP: cover property (st_r.mode == MCLP_SLEEP ##1 core.wakeIrq);
  COV_DEEP: cover property (isDeep ##1 core.wakeIrq);
  COV_FAIL: cover property ($rose(clockFail));
  COV_OWNER: cover property ($rose(st_r.ctlOwner));

endmodule : mclp_top
